//--- rtl/dsm_monitor.sv
// two-channel safe stop request monitor with axi4-lite registers
// What the document requires
// R1 - a high input withdraws the stop request, a low input requests it
// R2 - channel one is a selected control-unit input, channel two the pulse-enable terminal
// R3 - a request acts only on the drive this instance serves
// R4 - fault when the channels do not agree within the tolerance time
// R5 - mismatch gives a stop fault; extended set has own tolerance and fault bit
// R6 - pulses are cut as soon as one channel requests the stop
// R7 - too frequent switching raises the discrepancy fault with value 1000
// R8 - requester switches at least twice per five tolerance times, T apart
// R9 - configurable debounce on both request terminals
// R10 - up to eight selected control-unit inputs are anded into channel one
// R11 - the number of anded inputs equals the parallel unit count
// R12 - pulse-enable terminal is ignored unless terminal control is enabled
// R13 - a fault here does not force stop on other drives of a group
// R14 - integrator wires group inputs and pulse-enable terminals identically
// R15 - tolerance time must be shorter than the shortest switching interval
// R16 - after a failed cross-check pulses are suppressed after the stop delay
// R17 - tolerance timer starts at the first change, clears when channels agree
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dsm_defs.svh"
module dsm_monitor
	import dsm_pkg::*;
#(
	parameter int NUM_DI = 8,
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_DI-1:0] control_unit_input_states,
	input wire logic pulse_enable_terminal,
	output logic pulse_enable_out,
	output logic stop_fault,
	output logic irq
);
	function automatic dsm_word_t wmerge(input dsm_word_t old, input dsm_word_t d,
		input logic [3:0] s);
		dsm_word_t r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ands the first n selected inputs; a count of zero acts as one
	function automatic logic first_chan(input logic [NUM_DI-1:0] di, input logic [23:0] sel,
		input logic [3:0] cnt);
		logic r;
		logic [3:0] n;
		n = (cnt == 4'h0) ? 4'h1 : cnt;
		r = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < n) begin
				if (int'(sel[3*i +: 3]) < NUM_DI) begin
					r = r & di[sel[3*i +: 3]];
				end else begin
					r = 1'b0;
				end
			end
		end
		return r;
	endfunction

	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [ADDR_W-1:0] waddr_reg, waddr_next;
	dsm_word_t wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	dsm_word_t ctrl_reg, ctrl_next, sel_reg, sel_next, btol_reg, btol_next;
	dsm_word_t etol_reg, etol_next, deb_reg, deb_next, ss1_reg, ss1_next;
	logic [2:0] stat_reg, stat_next, mask_reg, mask_next;
	logic ack_reg, ack_next, irq_reg, irq_next;
	dsm_mon_t st_reg, st_next;
	dsm_word_t tmr_reg, tmr_next;
	logic fault_reg, fault_next, pe_reg, pe_next;
	logic [15:0] fval_reg, fval_next;
	logic ev_bdisc, ev_edisc, ev_freq, mismatch;
	logic wr_go, rd_go;
	logic term_en, ext_en, ch1_raw, ch2_raw, ch1_db, ch2_db, too_fast;
	dsm_word_t tol;

	assign term_en = ctrl_reg[`DSM_CTRL_TERM_BIT];
	assign ext_en = ctrl_reg[`DSM_CTRL_EXT_BIT];
	assign tol = ext_en ? etol_reg : btol_reg;
	// channel one from the anded selection, channel two from the terminal; both held high while terminal control is off
	assign ch1_raw = term_en ? first_chan(control_unit_input_states, sel_reg[23:0], // R2 R10 R11
		ctrl_reg[`DSM_CTRL_CNT_LSB +: 4]) : 1'b1;
	assign ch2_raw = term_en ? pulse_enable_terminal : 1'b1; // R2 R12

	dsm_debounce #(.CW(32)) u_deb_ch1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.limit(deb_reg),
		.din(ch1_raw),
		.dout(ch1_db)
	);

	dsm_debounce #(.CW(32)) u_deb_ch2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.limit(deb_reg),
		.din(ch2_raw),
		.dout(ch2_db)
	);

	dsm_switch_mon #(.CW(32)) u_switch (
		.aclk(aclk),
		.aresetn(aresetn),
		.tol(tol),
		.req({ch2_db, ch1_db}),
		.too_fast(too_fast)
	);

	// cross-check of the two channels; only this drive's pulses are touched
	always_comb begin
		st_next = st_reg;
		tmr_next = tmr_reg;
		fault_next = fault_reg;
		fval_next = fval_reg;
		ev_bdisc = 1'b0;
		ev_edisc = 1'b0;
		ev_freq = 1'b0;
		mismatch = ch1_db != ch2_db;
		unique case (st_reg)
			DSM_AGREE: begin
				if (mismatch) begin
					st_next = DSM_SKEW; // R17
					tmr_next = '0;
				end
			end
			DSM_SKEW: begin
				if (!mismatch) begin
					st_next = DSM_AGREE; // R17
				end else if (tmr_reg + 32'h1 >= tol) begin
					ev_bdisc = !ext_en; // R4 R5
					ev_edisc = ext_en; // R5
					st_next = DSM_STOP_DELAY;
					tmr_next = '0;
					fault_next = 1'b1;
					fval_next = 16'h0000;
				end else begin
					tmr_next = tmr_reg + 32'h1;
				end
			end
			DSM_STOP_DELAY: begin
				if (tmr_reg + 32'h1 >= ss1_reg) begin
					st_next = DSM_SUPPRESS; // R16
				end else begin
					tmr_next = tmr_reg + 32'h1;
				end
			end
			DSM_SUPPRESS: begin
				if (ack_reg && !mismatch) begin
					st_next = DSM_AGREE;
					fault_next = 1'b0;
					fval_next = 16'h0000;
				end
			end
		endcase
		if (too_fast && (st_reg == DSM_AGREE || st_reg == DSM_SKEW)) begin
			ev_freq = 1'b1; // R7
			st_next = DSM_STOP_DELAY;
			tmr_next = '0;
			fault_next = 1'b1;
			fval_next = `DSM_FREQ_FAULT_VAL; // R7
		end
		// low on either channel cuts pulses at once
		pe_next = ch1_db & ch2_db & (st_next != DSM_SUPPRESS); // R1 R3 R6 R13 R16
	end

	// bus slave, register file and interrupt status
	always_comb begin
		awready_next = awready_reg;
		wready_next = wready_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		ctrl_next = ctrl_reg;
		sel_next = sel_reg;
		btol_next = btol_reg;
		etol_next = etol_reg;
		deb_next = deb_reg;
		ss1_next = ss1_reg;
		mask_next = mask_reg;
		stat_next = stat_reg;
		ack_next = 1'b0;
		if (s_axi_awvalid && awready_reg) begin
			waddr_next = s_axi_awaddr;
			awready_next = 1'b0;
		end
		if (s_axi_wvalid && wready_reg) begin
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
			wready_next = 1'b0;
		end
		wr_go = !awready_reg && !wready_reg && !bvalid_reg;
		if (wr_go) begin
			bvalid_next = 1'b1;
			bresp_next = `DSM_RESP_OKAY;
			unique case (waddr_reg)
				`DSM_CTRL_OFF: begin
					ctrl_next = wmerge(ctrl_reg, wdata_reg, wstrb_reg);
					ctrl_next[`DSM_CTRL_ACK_BIT] = 1'b0;
					ack_next = wstrb_reg[0] && wdata_reg[`DSM_CTRL_ACK_BIT];
				end
				`DSM_SEL_OFF: sel_next = wmerge(sel_reg, wdata_reg, wstrb_reg);
				`DSM_BTOL_OFF: btol_next = wmerge(btol_reg, wdata_reg, wstrb_reg);
				`DSM_ETOL_OFF: etol_next = wmerge(etol_reg, wdata_reg, wstrb_reg);
				`DSM_DEB_OFF: deb_next = wmerge(deb_reg, wdata_reg, wstrb_reg);
				`DSM_SS1_OFF: ss1_next = wmerge(ss1_reg, wdata_reg, wstrb_reg);
				`DSM_MASK_OFF: begin
					if (wstrb_reg[0]) begin
						mask_next = wdata_reg[2:0];
					end
				end
				`DSM_STAT_OFF, `DSM_STATE_OFF: bresp_next = `DSM_RESP_OKAY;
				default: bresp_next = `DSM_RESP_SLVERR;
			endcase
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
			awready_next = 1'b1;
			wready_next = 1'b1;
		end
		rd_go = s_axi_arvalid && arready_reg;
		if (rd_go) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rresp_next = `DSM_RESP_OKAY;
			rdata_next = 32'h0000_0000;
			unique case (s_axi_araddr)
				`DSM_CTRL_OFF: rdata_next = ctrl_reg;
				`DSM_SEL_OFF: rdata_next = sel_reg;
				`DSM_BTOL_OFF: rdata_next = btol_reg;
				`DSM_ETOL_OFF: rdata_next = etol_reg;
				`DSM_DEB_OFF: rdata_next = deb_reg;
				`DSM_SS1_OFF: rdata_next = ss1_reg;
				`DSM_STAT_OFF: begin
					rdata_next[2:0] = stat_reg;
					stat_next = 3'h0;
				end
				`DSM_MASK_OFF: rdata_next[2:0] = mask_reg;
				`DSM_STATE_OFF: rdata_next = {fval_reg, 8'h00, pulse_enable_out,
					stop_fault, ch2_db, ch1_db, 4'(st_reg)};
				default: rresp_next = `DSM_RESP_SLVERR;
			endcase
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
		// a new event wins over the read that clears
		stat_next[`DSM_STAT_BDISC_BIT] = stat_next[`DSM_STAT_BDISC_BIT] | ev_bdisc;
		stat_next[`DSM_STAT_EDISC_BIT] = stat_next[`DSM_STAT_EDISC_BIT] | ev_edisc;
		stat_next[`DSM_STAT_FREQ_BIT] = stat_next[`DSM_STAT_FREQ_BIT] | ev_freq;
		irq_next = |(stat_next & mask_next);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= `DSM_RESP_OKAY;
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rresp_reg <= `DSM_RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			waddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			ctrl_reg <= `DSM_CTRL_RST;
			sel_reg <= `DSM_SEL_RST;
			btol_reg <= `DSM_BTOL_RST;
			etol_reg <= `DSM_ETOL_RST;
			deb_reg <= `DSM_DEB_RST;
			ss1_reg <= `DSM_SS1_RST;
			stat_reg <= 3'h0;
			mask_reg <= 3'h0;
			ack_reg <= 1'b0;
			irq_reg <= 1'b0;
			st_reg <= DSM_AGREE;
			tmr_reg <= 32'h0000_0000;
			fault_reg <= 1'b0;
			fval_reg <= 16'h0000;
			pe_reg <= 1'b0;
		end else begin
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			ctrl_reg <= ctrl_next;
			sel_reg <= sel_next;
			btol_reg <= btol_next;
			etol_reg <= etol_next;
			deb_reg <= deb_next;
			ss1_reg <= ss1_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			ack_reg <= ack_next;
			irq_reg <= irq_next;
			st_reg <= st_next;
			tmr_reg <= tmr_next;
			fault_reg <= fault_next;
			fval_reg <= fval_next;
			pe_reg <= pe_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign pulse_enable_out = pe_reg;
	assign stop_fault = fault_reg;
	assign irq = irq_reg;

	sequence s_skew_expire;
		st_reg == DSM_SKEW && mismatch && (tmr_reg + 32'h1 >= tol);
	endsequence

	AST_PE_CUT: assert property (@(posedge aclk) disable iff (!aresetn) // R1 R2 R6
		(!ch1_db || !ch2_db) |=> !pulse_enable_out)
		else $error("pulses not cut after a one-channel request");
	AST_FAULT_TOL: assert property (@(posedge aclk) disable iff (!aresetn) // R4
		s_skew_expire |=> stop_fault && st_reg == DSM_STOP_DELAY)
		else $error("discrepancy fault missing after tolerance time");
	AST_EXT_CODE: assert property (@(posedge aclk) disable iff (!aresetn) // R5
		s_skew_expire ##0 ext_en |=> stat_reg[`DSM_STAT_EDISC_BIT] && !stat_reg[`DSM_STAT_BDISC_BIT])
		else $error("extended discrepancy bit not set");
	AST_SKEW_CLR: assert property (@(posedge aclk) disable iff (!aresetn) // R17
		st_reg == DSM_SKEW && !mismatch && !too_fast |=> st_reg == DSM_AGREE)
		else $error("tolerance timer not cleared when channels agree");
	AST_SS1: assert property (@(posedge aclk) disable iff (!aresetn) // R16
		st_reg == DSM_STOP_DELAY && (tmr_reg + 32'h1 >= ss1_reg) |=> !pulse_enable_out[*2])
		else $error("pulses not suppressed after the stop delay");
	AST_FREQ_VAL: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		too_fast && (st_reg == DSM_AGREE || st_reg == DSM_SKEW)
		|=> stop_fault && fval_reg == `DSM_FREQ_FAULT_VAL)
		else $error("frequent switching fault value wrong");
	AST_EP_IGNORED: assert property (@(posedge aclk) disable iff (!aresetn) // R12
		!term_en |-> ch2_raw && ch1_raw)
		else $error("pulse-enable terminal read while terminal control is off");
	AST_AND_COUNT: assert property (@(posedge aclk) disable iff (!aresetn) // R10 R11
		term_en && ctrl_reg[`DSM_CTRL_CNT_LSB +: 4] >= 4'h2
		&& !control_unit_input_states[sel_reg[5:3]] |-> !ch1_raw)
		else $error("second selected input not anded into channel one");
endmodule
`default_nettype wire

//--- include/dsm_defs.svh
// register offsets, field positions and reset values of the safe input monitor
`ifndef DSM_DEFS_SVH
`define DSM_DEFS_SVH
`define DSM_CTRL_OFF 8'h00
`define DSM_SEL_OFF 8'h04
`define DSM_BTOL_OFF 8'h08
`define DSM_ETOL_OFF 8'h0C
`define DSM_DEB_OFF 8'h10
`define DSM_SS1_OFF 8'h14
`define DSM_STAT_OFF 8'h18
`define DSM_MASK_OFF 8'h1C
`define DSM_STATE_OFF 8'h20
`define DSM_CTRL_TERM_BIT 0
`define DSM_CTRL_EXT_BIT 1
`define DSM_CTRL_ACK_BIT 2
`define DSM_CTRL_CNT_LSB 4
`define DSM_STAT_BDISC_BIT 0
`define DSM_STAT_EDISC_BIT 1
`define DSM_STAT_FREQ_BIT 2
`define DSM_CTRL_RST 32'h0000_0011
`define DSM_SEL_RST 32'h00FA_C688
`define DSM_BTOL_RST 32'h0000_2710
`define DSM_ETOL_RST 32'h0000_2710
`define DSM_DEB_RST 32'h0000_0064
`define DSM_SS1_RST 32'h0000_4E20
`define DSM_FREQ_FAULT_VAL 16'h03E8
`define DSM_RESP_OKAY 2'h0
`define DSM_RESP_SLVERR 2'h2
`endif

//--- include/dsm_pkg.sv
// types of the safe input monitor
package dsm_pkg;
	typedef enum {
		DSM_AGREE,
		DSM_SKEW,
		DSM_STOP_DELAY,
		DSM_SUPPRESS
	} dsm_mon_t;
	typedef logic [31:0] dsm_word_t;
endpackage

//--- rtl/dsm_debounce.sv
// debounce filter for one request terminal
`timescale 1ns/1ps
`default_nettype none
module dsm_debounce #(
	parameter int CW = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [CW-1:0] limit,
	input wire logic din,
	output logic dout
);
	logic dout_reg, dout_next;
	logic [CW-1:0] cnt_reg, cnt_next;

	// output follows only after the input has differed for limit+1 cycles in a row
	always_comb begin
		dout_next = dout_reg;
		cnt_next = '0;
		if (din != dout_reg) begin
			if (cnt_reg >= limit) begin
				dout_next = din; // R9
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dout_reg <= 1'b0;
			cnt_reg <= '0;
		end else begin
			dout_reg <= dout_next;
			cnt_reg <= cnt_next;
		end
	end

	assign dout = dout_reg;

	AST_DEB_STABLE: assert property (@(posedge aclk) disable iff (!aresetn) // R9
		$changed(dout_reg) |-> ($past(din) == dout_reg) && ($past(cnt_reg) >= $past(limit)))
		else $error("debounced output changed before the input was stable");
endmodule
`default_nettype wire

//--- rtl/dsm_switch_mon.sv
// watches the spacing between switching operations of the two channels
`timescale 1ns/1ps
`default_nettype none
module dsm_switch_mon #(
	parameter int CW = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [CW-1:0] tol,
	input wire logic [1:0] req,
	output logic too_fast
);
	logic [1:0] prev_reg, prev_next;
	logic [CW-1:0] gap_reg, gap_next;
	logic fast_reg, fast_next;
	logic sw;

	always_comb begin
		sw = |(req ^ prev_reg);
		prev_next = req;
		fast_next = sw && (gap_reg < tol); // R7
		if (sw) begin
			gap_next = '0;
		end else if (gap_reg != '1) begin
			gap_next = gap_reg + 1'b1;
		end else begin
			gap_next = gap_reg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_reg <= 2'h0;
			gap_reg <= '1;
			fast_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
			gap_reg <= gap_next;
			fast_reg <= fast_next;
		end
	end

	assign too_fast = fast_reg;

	AST_FAST_GAP: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		$changed(req) && (gap_reg < tol) |=> too_fast)
		else $error("switching closer than the tolerance time not flagged");
endmodule
`default_nettype wire

//--- verif/dsm_switch_model.sv
// two-channel safety switch model driving both request paths
`timescale 1ns/1ps
`default_nettype none
module dsm_switch_model (
	input wire logic aclk,
	input wire logic [7:0] cu_cmd,
	input wire logic pe_cmd,
	input wire logic test_pulse,
	output logic [7:0] cu_out,
	output logic pe_out
);
	initial begin
		cu_out = 8'hFF;
		pe_out = 1'b1;
	end
	// contacts move just after the edge; a test pulse opens both channels for one cycle
	always @(posedge aclk) begin
		cu_out <= test_pulse ? 8'h00 : cu_cmd;
		pe_out <= test_pulse ? 1'b0 : pe_cmd;
	end
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the safe input monitor
`timescale 1ns/1ps
`default_nettype none
`include "dsm_defs.svh"
module tb;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] awaddr = 0;
	logic [7:0] araddr = 0;
	logic awvalid = 0;
	logic wvalid = 0;
	logic arvalid = 0;
	logic bready = 0;
	logic rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd_val, sel_v;
	logic [7:0] cu_cmd = 8'hFF;
	logic [7:0] cu;
	logic pe_cmd = 1;
	logic pe, tp = 0;
	logic pulse_enable_out, stop_fault, irq, drop;
	int err_count = 0;
	int n_compared = 0;
	int seed = 97;
	int cnt_v = 1;
	logic [31:0] rst_v [6] = '{`DSM_CTRL_RST, `DSM_SEL_RST, `DSM_BTOL_RST, `DSM_ETOL_RST,
		`DSM_DEB_RST, `DSM_SS1_RST};
	logic [31:0] cfg_v [6] = '{32'h0000_0011, `DSM_SEL_RST, 32'h8, 32'hC, 32'h2, 32'h6};

	always #50 aclk = ~aclk;

	dsm_monitor dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .control_unit_input_states(cu),
		.pulse_enable_terminal(pe), .pulse_enable_out(pulse_enable_out),
		.stop_fault(stop_fault), .irq(irq));

	dsm_switch_model pm (.aclk(aclk), .cu_cmd(cu_cmd), .pe_cmd(pe_cmd), .test_pulse(tp),
		.cu_out(cu), .pe_out(pe));

	task end_of_test;
		$display("compared %0d, errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task timeout(input int n);
		if (n >= 200) begin
			err_count++;
			$display("Error at %0t: bus wait ran out", $time);
			end_of_test();
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready === 1'b1)
				awvalid <= 0;
			if (wvalid && wready === 1'b1)
				wvalid <= 0;
		end while (bvalid !== 1'b1 && n < 200);
		timeout(n);
		resp = bresp;
		bready <= 0;
	endtask

	task rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready === 1'b1)
				arvalid <= 0;
		end while (rvalid !== 1'b1 && n < 200);
		timeout(n);
		rd_val = rdata;
		resp = rresp;
		rready <= 0;
	endtask

	task wait_for(input int w, input logic v, input int lim);
		int n;
		logic s;
		n = 0;
		do begin
			@(posedge aclk);
			#1;
			s = (w == 0) ? pulse_enable_out : (w == 1) ? stop_fault : irq;
			n++;
		end while (s !== v && n < lim);
		chk(s, v, "output level");
	endtask

	// behavioural and of the selected control-unit inputs
	function automatic logic exp_ch1(input logic [7:0] c, input logic [31:0] s, input int k);
		logic r;
		r = 1;
		if (k == 0)
			k = 1;
		for (int i = 0; i < k; i++)
			r &= c[s[3*i +: 3]];
		return r;
	endfunction

	task st_chk;
		rd(`DSM_STATE_OFF);
		chk(rd_val[4], exp_ch1(cu, sel_v, cnt_v), "channel one");
		chk(rd_val[5], pe, "channel two");
		chk(rd_val[7], exp_ch1(cu, sel_v, cnt_v) & pe, "pulse state");
	endtask

	task one_side(input logic on_pe);
		if (on_pe)
			pe_cmd <= 0;
		else
			cu_cmd <= 8'h00;
		wait_for(0, 0, 10);
		chk(stop_fault, 0, "pulses cut before fault");
		wait_for(1, 1, 40);
		pe_cmd <= 1;
		cu_cmd <= 8'hFF;
	endtask

	initial begin
		sel_v = `DSM_SEL_RST;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i));
			chk(rd_val, rst_v[i], "reset value");
			wr(8'(4 * i), cfg_v[i]);
			chk(resp, `DSM_RESP_OKAY, "write response");
		end
		rd(8'h40);
		chk(resp, `DSM_RESP_SLVERR, "unmapped read");
		wr(8'h44, 32'h1);
		chk(resp, `DSM_RESP_SLVERR, "unmapped write");
		wr(`DSM_MASK_OFF, 32'h7);
		wait_for(0, 1, 30);
		st_chk();
		@(posedge aclk);
		tp <= 1;
		drop = 0;
		for (int i = 0; i < 12; i++) begin
			@(posedge aclk);
			tp <= 0;
			#1;
			drop |= !pulse_enable_out;
		end
		chk(drop, 0, "test pulse filtered");
		one_side(1);
		wait_for(2, 1, 4);
		rd(`DSM_STAT_OFF);
		chk(rd_val[2:0], 3'h1, "basic discrepancy status");
		rd(`DSM_STAT_OFF);
		chk(rd_val[2:0], 3'h0, "status cleared by read");
		for (int i = 0; i < 20 && rd_val[3:0] !== 4'h3; i++)
			rd(`DSM_STATE_OFF);
		chk(rd_val[3:0], 4'h3, "suppress after stop delay");
		repeat (6) @(posedge aclk);
		wr(`DSM_CTRL_OFF, 32'h15);
		wait_for(0, 1, 30);
		wr(`DSM_CTRL_OFF, 32'h13);
		one_side(0);
		rd(`DSM_STAT_OFF);
		chk(rd_val[1], 1, "extended discrepancy status");
		repeat (6) @(posedge aclk);
		wr(`DSM_CTRL_OFF, 32'h17);
		wr(`DSM_CTRL_OFF, 32'h11);
		wr(`DSM_MASK_OFF, 32'h0);
		rd(`DSM_STAT_OFF);
		// both channels switch together but closer than the tolerance time
		for (int i = 0; i < 4; i++) begin
			cu_cmd <= 8'h00;
			pe_cmd <= 0;
			repeat (5) @(posedge aclk);
			cu_cmd <= 8'hFF;
			pe_cmd <= 1;
			repeat (5) @(posedge aclk);
		end
		rd(`DSM_STATE_OFF);
		chk(rd_val[31:16], `DSM_FREQ_FAULT_VAL, "fault value");
		rd(`DSM_STAT_OFF);
		chk(rd_val[2], 1, "frequent switching status");
		chk(irq, 0, "masked interrupt");
		wr(`DSM_MASK_OFF, 32'h7);
		wr(`DSM_CTRL_OFF, 32'h15);
		sel_v = 32'h2B;
		cnt_v = 2;
		wr(`DSM_SEL_OFF, sel_v);
		wr(`DSM_CTRL_OFF, 32'h21);
		cu_cmd <= 8'($random(seed)) | 8'h28;
		wait_for(0, 1, 30);
		st_chk();
		cu_cmd <= 8'($random(seed)) & 8'hDF | 8'h08;
		wait_for(0, 0, 10);
		st_chk();
		wr(`DSM_CTRL_OFF, 32'h10);
		cu_cmd <= 8'h00;
		pe_cmd <= 0;
		repeat (6) @(posedge aclk);
		wr(`DSM_CTRL_OFF, 32'h14);
		wait_for(0, 1, 40);
		end_of_test();
	end
endmodule
`default_nettype wire
